//--- core/mcu_address_decoder.sv
// address decoder: steers core accesses to memory selects or peripheral strobes
// assumes a registered access address valid for one bus cycle at i_acc_valid
`timescale 1ns/100ps
`default_nettype none
module mcu_address_decoder (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // access from core
    input wire logic i_acc_valid,
    input wire logic [addr_dec_pkg::ADDR_W-1:0] i_addr,
    input wire logic i_write,
    input wire logic [1:0] i_size,
    // configuration
    input wire logic i_boot_select_pin,
    input wire logic [7:0] i_core_config_register,
    input wire logic [addr_dec_pkg::EXT_SEL_N-1:0] i_write_permit,
    // memory selects, active low
    output logic o_ext_select_zero_n,
    output logic o_ext_select_one_n,
    output logic o_ext_select_two_n,
    output logic o_ext_select_three_n,
    output logic o_ext_select_four_n,
    output logic o_internal_ram_select_n,
    output logic o_internal_boot_select_n,
    output logic o_debug_block_select_n,
    output logic o_shared_host_ram_select_n,
    output logic o_shared_host_ctrl_select_n,
    // peripheral strobes, active low
    output logic o_strobe0_n,
    output logic o_strobe1_n,
    output logic [addr_dec_pkg::SLOT_N-1:0] o_slot_select_n,
    output logic o_sys_block_select_n,
    // answer
    output logic o_is_peripheral,
    output logic [1:0] o_slot_width,
    output logic o_abort,
    output logic o_error
);
    import addr_dec_pkg::*;

    logic wide_map;
    logic [31:0] win;
    logic [15:0] page;
    logic [15:0] off;
    logic [4:0] slot;
    logic sel0, sel1, sel2, sel3, sel4, ram, boot, dbg, hram, hctrl;
    logic stb0, stb1, sysb, slot_ok;
    logic [2:0] ext_idx;
    logic ext_hit;
    logic [1:0] width;
    logic wr_blocked;
    logic [1:0] width_r;
    logic abort_r, error_r;
    logic [1:0] width_nxt;
    logic abort_nxt, error_nxt;
    target_t tgt;

    assign wide_map = i_core_config_register[CONF_MAP_BIT];
    assign win = wide_map ? WIN8M_SIZE : WIN4M_SIZE;
    assign page = i_addr[31:16];
    assign off = i_addr[15:0];
    assign slot = off[15:SLOT_LSB];

    // memory side windows
    always_comb begin
        sel0 = 1'b0;
        sel1 = 1'b0;
        sel2 = 1'b0;
        sel3 = 1'b0;
        sel4 = 1'b0;
        ram = 1'b0;
        boot = 1'b0;
        dbg = 1'b0;
        hram = 1'b0;
        hctrl = 1'b0;
        if (i_addr < CS0_BASE + win) begin
            if (!i_boot_select_pin && i_addr <= BOOT_MEM_TOP) begin
                boot = 1'b1;
            end else begin
                sel0 = i_boot_select_pin || i_addr >= CS0_BOOT_BASE;
            end
        end
        if (i_addr >= RAM_BASE && i_addr <= RAM_TOP) begin
            ram = 1'b1;
        end
        if (i_addr >= CS1_BASE && i_addr < CS1_BASE + win) begin
            sel1 = 1'b1;
        end
        if (i_addr >= CS2_BASE && i_addr < CS2_BASE + win) begin
            sel2 = 1'b1;
        end
        if (i_addr >= CS3_BASE && i_addr < CS3_BASE + win) begin
            sel3 = 1'b1;
        end
        if (i_addr >= CS4_BASE && i_addr <= CS4_TOP) begin
            sel4 = 1'b1;
        end
        if (i_addr >= CS0_IMG_BASE && i_addr < CS0_IMG_BASE + win && i_addr < BOOT_BASE) begin
            sel0 = 1'b1;
        end
        if (i_boot_select_pin && i_addr >= BOOT_BASE && i_addr <= BOOT_TOP) begin
            boot = 1'b1;
        end
        if (i_addr >= DEBUG_BASE && i_addr <= DEBUG_TOP) begin
            dbg = 1'b1;
        end
        if (i_addr >= HRAM_BASE && i_addr <= HRAM_TOP) begin
            hram = i_size != WIDTH_8;
        end
        if (i_addr >= HRAM_CTRL && i_addr <= HRAM_CTRL_TOP) begin
            hctrl = 1'b1;
        end
    end

    // peripheral strobe pages
    always_comb begin
        stb0 = 1'b0;
        stb1 = 1'b0;
        sysb = 1'b0;
        slot_ok = 1'b0;
        width = WIDTH_16;
        if (page == STROBE0_PAGE) begin
            if (off >= WDOG_BASE) begin
                slot_ok = off <= WDOG_TOP;
                sysb = off > WDOG_TOP;
                stb0 = 1'b1;
            end else begin
                stb0 = 1'b1;
                slot_ok = S0_USED_SLOTS[slot];
                width = S0_BYTE_SLOTS[slot] ? WIDTH_8 : WIDTH_16;
            end
        end else if (page == STROBE1_PAGE) begin
            stb1 = 1'b1;
            if (slot == CONF_SLOT) begin
                slot_ok = off <= CONF_WORD_TOP || (off >= DIE_ID_BASE && off <= DIE_ID_TOP);
            end else begin
                slot_ok = S1_USED_SLOTS[slot];
            end
            width = S1_BYTE_SLOTS[slot] ? WIDTH_8 : WIDTH_16;
        end
    end

    // select zero through four, internal RAM as select 5
    always_comb begin
        ext_idx = 3'h0;
        ext_hit = 1'b1;
        if (sel0) begin
            ext_idx = 3'h0;
        end else if (sel1) begin
            ext_idx = 3'h1;
        end else if (sel2) begin
            ext_idx = 3'h2;
        end else if (sel3) begin
            ext_idx = 3'h3;
        end else if (sel4) begin
            ext_idx = 3'h4;
        end else if (ram) begin
            ext_idx = 3'h5;
        end else begin
            ext_hit = boot;
        end
    end

    assign wr_blocked = i_write && ext_hit && !boot && !i_write_permit[ext_idx];

    // target class of the access, one hot
    always_comb begin
        tgt = TGT_NONE;
        if (sel0 || sel1 || sel2 || sel3 || sel4) begin
            tgt = TGT_EXT;
        end else if (ram || boot) begin
            tgt = TGT_INT;
        end else if (dbg || hram || hctrl) begin
            tgt = TGT_SYS;
        end else if (stb0 && (slot_ok || sysb)) begin
            tgt = TGT_STB0;
        end else if (stb1 && slot_ok) begin
            tgt = TGT_STB1;
        end
    end

    // selects: active low, qualified by valid; external and internal RAM selects also by write permit
    logic mem_go, per_go;
    assign mem_go = i_acc_valid && !wr_blocked;
    assign per_go = i_acc_valid && (stb0 || stb1) && (slot_ok || sysb);
    assign o_ext_select_zero_n = !(mem_go && sel0);
    assign o_ext_select_one_n = !(mem_go && sel1);
    assign o_ext_select_two_n = !(mem_go && sel2);
    assign o_ext_select_three_n = !(mem_go && sel3);
    assign o_ext_select_four_n = !(mem_go && sel4);
    assign o_internal_ram_select_n = !(mem_go && ram);
    assign o_internal_boot_select_n = !(mem_go && boot);
    assign o_debug_block_select_n = !(i_acc_valid && dbg);
    assign o_shared_host_ram_select_n = !(i_acc_valid && hram);
    assign o_shared_host_ctrl_select_n = !(i_acc_valid && hctrl);
    assign o_strobe0_n = !(per_go && stb0);
    assign o_strobe1_n = !(per_go && stb1);
    assign o_sys_block_select_n = !(per_go && sysb);
    always_comb begin
        o_slot_select_n = '1;
        if (per_go && slot_ok) begin
            o_slot_select_n[slot] = 1'b0;
        end
    end
    assign o_is_peripheral = stb0 || stb1;

    // answer flags, one cycle after the access
    assign abort_nxt = i_acc_valid && wr_blocked;
    assign error_nxt = i_acc_valid && tgt == TGT_NONE;
    assign width_nxt = (stb0 || stb1) ? width : WIDTH_32;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            abort_r <= 1'b0;
        end else begin
            abort_r <= abort_nxt;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            error_r <= 1'b0;
        end else begin
            error_r <= error_nxt;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            width_r <= WIDTH_16;
        end else begin
            width_r <= width_nxt;
        end
    end
    assign o_abort = abort_r;
    assign o_error = error_r;
    assign o_slot_width = width_r;
endmodule
`default_nettype wire

//--- pkg/addr_dec_pkg.sv
// address decoder package: map windows, slot layout, select indices
// assumes a 32-bit processor address space
package addr_dec_pkg;
    localparam int ADDR_W = 32;
    localparam int EXT_SEL_N = 6;
    localparam int SLOT_N = 32;
    localparam int CONF_MAP_BIT = 3;
    localparam int WE_BIT = 7;
    // external/internal memory window bases
    localparam logic [31:0] CS0_BASE = 32'h0000_0000;
    localparam logic [31:0] BOOT_MEM_TOP = 32'h0000_1fff;
    localparam logic [31:0] CS0_BOOT_BASE = 32'h0000_2000;
    localparam logic [31:0] RAM_BASE = 32'h0080_0000;
    localparam logic [31:0] RAM_TOP = 32'h00bf_ffff;
    localparam logic [31:0] CS1_BASE = 32'h0100_0000;
    localparam logic [31:0] CS2_BASE = 32'h0180_0000;
    localparam logic [31:0] CS3_BASE = 32'h0200_0000;
    localparam logic [31:0] CS4_BASE = 32'h0280_0000;
    localparam logic [31:0] CS4_TOP = 32'h02bf_ffff;
    localparam logic [31:0] CS0_IMG_BASE = 32'h0300_0000;
    localparam logic [31:0] BOOT_BASE = 32'h0380_0000;
    localparam logic [31:0] BOOT_TOP = 32'h03bf_ffff;
    localparam logic [31:0] DEBUG_BASE = 32'h03c0_0000;
    localparam logic [31:0] DEBUG_TOP = 32'h03ff_ffff;
    localparam logic [31:0] WIN4M_SIZE = 32'h0040_0000;
    localparam logic [31:0] WIN8M_SIZE = 32'h0080_0000;
    localparam logic [31:0] UNALLOC_BASE = 32'h0400_0000;
    localparam logic [31:0] UNALLOC_TOP = 32'hffcf_ffff;
    localparam logic [31:0] HRAM_BASE = 32'hffd0_0000;
    localparam logic [31:0] HRAM_TOP = 32'hffd0_3fff;
    localparam logic [31:0] HRAM_CTRL = 32'hffe0_0000;
    localparam logic [31:0] HRAM_CTRL_TOP = 32'hffe0_0001;
    // peripheral strobe pages
    localparam logic [15:0] STROBE0_PAGE = 16'hffff;
    localparam logic [15:0] STROBE1_PAGE = 16'hfffe;
    localparam int SLOT_LSB = 11;
    localparam logic [15:0] WDOG_BASE = 16'hf800;
    localparam logic [15:0] WDOG_TOP = 16'hf8ff;
    localparam logic [15:0] DMA_BASE = 16'hfc00;
    localparam logic [15:0] DMA_TOP = 16'hfcff;
    localparam logic [15:0] CONF_BASE = 16'hf000;
    localparam logic [15:0] CONF_WORD_TOP = 16'hf00f;
    localparam logic [15:0] DIE_ID_BASE = 16'hf010;
    localparam logic [15:0] DIE_ID_TOP = 16'hf017;
    localparam logic [4:0] IRDA_SLOT = 5'h0a;
    localparam logic [4:0] CONF_SLOT = 5'h1e;
    // populated slots: bit set means a device answers in that slot
    localparam logic [31:0] S0_USED_SLOTS = 32'h010c_5c04;
    localparam logic [31:0] S1_USED_SLOTS = 32'h4003_a3fb;
    // slot widths: bit set means byte-wide slot
    localparam logic [31:0] S0_BYTE_SLOTS = 32'h0000_1c00;
    localparam logic [31:0] S1_BYTE_SLOTS = 32'h0003_8028;
    // data width codes
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_32 = 2'h2;
    // default write-permit reset: all enabled except select 0
    localparam logic [5:0] WE_RESET = 6'h3e;
    // target classes
    typedef enum logic [5:0] {
        TGT_NONE = 6'b000001,
        TGT_EXT = 6'b000010,
        TGT_INT = 6'b000100,
        TGT_SYS = 6'b001000,
        TGT_STB0 = 6'b010000,
        TGT_STB1 = 6'b100000
    } target_t;
endpackage

//--- testbench/core_model.sv
// processor core model issuing single-cycle accesses
// assumes the bench calls issue and idle in turn
`timescale 1ns/100ps
`default_nettype none
module core_model (
    input wire logic i_clk,
    output logic o_acc_valid,
    output logic [31:0] o_addr,
    output logic o_write,
    output logic [1:0] o_size
);
    initial begin
        o_acc_valid = 1'b0;
        o_addr = 32'h0;
        o_write = 1'b0;
        o_size = 2'h2;
    end
    task automatic issue(input logic [31:0] ad, input logic wr, input logic [1:0] sz);
        @(negedge i_clk);
        o_acc_valid = 1'b1;
        o_addr = ad;
        o_write = wr;
        o_size = sz;
    endtask
    // released bus shows inverted address and write, not the last value
    task automatic idle();
        @(negedge i_clk);
        o_acc_valid = 1'b0;
        o_addr = ~o_addr;
        o_write = ~o_write;
    endtask
endmodule
`default_nettype wire

//--- testbench/mcu_address_decoder_properties.sv
// checker for the address decoder ports
// assumes a single clock domain and async low reset
`timescale 1ns/100ps
`default_nettype none
module mcu_address_decoder_checker (
    input wire logic i_clk, i_nrst, i_acc_valid, i_write, i_boot_select_pin,
    input wire logic [31:0] i_addr,
    input wire logic [7:0] i_core_config_register,
    input wire logic [5:0] i_write_permit,
    input wire logic o_ext_select_zero_n, o_ext_select_one_n, o_internal_ram_select_n,
    input wire logic o_internal_boot_select_n, o_debug_block_select_n, o_strobe0_n, o_strobe1_n,
    input wire logic [31:0] o_slot_select_n,
    input wire logic [1:0] o_slot_width,
    input wire logic o_abort, o_error
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    logic d;
    assign d = i_acc_valid && !i_core_config_register[3];
    cs1_default_a: assert property (d && !i_write && i_addr[31:22] == 10'h004 |-> !o_ext_select_one_n)
        else $error("select one missing");
    boot_low_a: assert property (i_acc_valid && !i_boot_select_pin && i_addr < 32'h2000
        |-> !o_internal_boot_select_n && o_ext_select_zero_n) else $error("boot window wrong");
    cs0_high_a: assert property (d && !i_write && i_boot_select_pin && i_addr < 32'h0040_0000
        |-> !o_ext_select_zero_n) else $error("select zero missing");
    ram_win_a: assert property (i_acc_valid && !i_write && i_addr[31:22] == 10'h002
        |-> !o_internal_ram_select_n) else $error("ram select missing");
    wide_cs0_a: assert property (i_acc_valid && !i_write && i_boot_select_pin && i_core_config_register[3]
        && i_addr[31:22] == 10'h001 |-> !o_ext_select_zero_n) else $error("wide select zero missing");
    debug_win_a: assert property (d && i_addr[31:22] == 10'h00f |-> !o_debug_block_select_n)
        else $error("debug select missing");
    unalloc_err_a: assert property (i_acc_valid && i_addr >= 32'h0400_0000 && i_addr <= 32'hffcf_ffff
        |-> o_strobe0_n && o_ext_select_zero_n ##1 o_error) else $error("unallocated not refused");
    write_abort_a: assert property (d && i_write && !i_write_permit[1] && i_addr[31:22] == 10'h004
        |-> o_ext_select_one_n ##1 o_abort) else $error("blocked write not aborted");
    idle_quiet_a: assert property (!i_acc_valid |-> o_ext_select_zero_n && o_strobe0_n && o_strobe1_n
        && &o_slot_select_n) else $error("select while idle");
    irda_slot_a: assert property (i_acc_valid && i_addr[31:11] == 21'h1fffea
        |-> !o_slot_select_n[10] && !o_strobe0_n ##1 o_slot_width == 2'h0) else $error("infrared slot wrong");
    reserved_slot_a: assert property (i_acc_valid && i_addr[31:11] == 21'h1fffe0
        |-> &o_slot_select_n && o_strobe0_n ##1 o_error) else $error("reserved slot selected");
    cover property (i_acc_valid && !o_strobe1_n);
    cover property (o_abort);
    cover property (o_error);
endmodule
bind mcu_address_decoder mcu_address_decoder_checker u_chk (.i_clk, .i_nrst, .i_acc_valid, .i_write,
    .i_boot_select_pin, .i_addr, .i_core_config_register, .i_write_permit, .o_ext_select_zero_n,
    .o_ext_select_one_n, .o_internal_ram_select_n, .o_internal_boot_select_n, .o_debug_block_select_n,
    .o_strobe0_n, .o_strobe1_n, .o_slot_select_n, .o_slot_width, .o_abort, .o_error);
`default_nettype wire

//--- testbench/tb.sv
// bench for the address decoder
// assumes core_model and the checker are compiled before it
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic i_clk = 0, i_nrst = 0, boot = 1, v, w, s0, s1, s2, s3, s4, sr, sb, sd, sh, sc, p0, p1, sy, ab, er, pi;
    logic [7:0] cfg = 8'h00;
    logic [5:0] wp = 6'h3f;
    logic [31:0] a, slot;
    logic [1:0] sz, wd;
    logic [1:0] asz = 2'h2;
    logic [12:0] sel;
    int errors = 0, tests_run = 0, cyc = 0;
    always #20 i_clk = ~i_clk;
    assign sel = ~{sy, s0, s1, s2, s3, s4, sr, sb, sd, sh, sc, p0, p1};
    core_model u_core_model (.i_clk(i_clk), .o_acc_valid(v), .o_addr(a), .o_write(w), .o_size(sz));
    mcu_address_decoder u_mcu_address_decoder (.i_clk(i_clk), .i_nrst(i_nrst), .i_acc_valid(v),
        .i_addr(a), .i_write(w), .i_size(sz), .i_boot_select_pin(boot), .i_core_config_register(cfg),
        .i_write_permit(wp), .o_ext_select_zero_n(s0), .o_ext_select_one_n(s1), .o_ext_select_two_n(s2),
        .o_ext_select_three_n(s3), .o_ext_select_four_n(s4), .o_internal_ram_select_n(sr),
        .o_internal_boot_select_n(sb), .o_debug_block_select_n(sd), .o_shared_host_ram_select_n(sh),
        .o_shared_host_ctrl_select_n(sc), .o_strobe0_n(p0), .o_strobe1_n(p1), .o_slot_select_n(slot),
        .o_sys_block_select_n(sy), .o_is_peripheral(pi), .o_slot_width(wd), .o_abort(ab), .o_error(er));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic [31:0] ad, input logic wr, input logic [12:0] e, input logic [31:0] es,
        input logic [1:0] ee);
        u_core_model.issue(ad, wr, asz);
        #5;
        chk({19'h0, sel}, {19'h0, e});
        chk({31'h0, pi}, {31'h0, (ad[31:17] == 15'h7fff)});
        chk(~slot, es);
        @(posedge i_clk);
        #1;
        chk({30'h0, ab, er}, {30'h0, ee});
        u_core_model.idle();
    endtask
    task automatic t_default();
        logic [31:0] ad [11] = '{32'h0, 32'h003f_ffff, 32'h0100_0000, 32'h0180_0000, 32'h0200_0000,
            32'h0280_0000, 32'h0080_0000, 32'h0380_0000, 32'h03c0_0000, 32'hffd0_0000, 32'hffe0_0000};
        logic [12:0] ex [11] = '{13'h800, 13'h800, 13'h400, 13'h200, 13'h100, 13'h080, 13'h040, 13'h020,
            13'h010, 13'h008, 13'h004};
        for (int i = 0; i < 11; i++) begin
            acc(ad[i], 1'b0, ex[i], 32'h0, 2'h0);
        end
        chk({30'h0, wd}, 32'h2);
    endtask
    task automatic t_boot_wide();
        boot = 1'b0;
        acc(32'h0000_1fff, 1'b0, 13'h020, 32'h0, 2'h0);
        acc(32'h0000_2000, 1'b0, 13'h800, 32'h0, 2'h0);
        acc(32'h0300_0000, 1'b0, 13'h800, 32'h0, 2'h0);
        boot = 1'b1;
        cfg = 8'h08;
        acc(32'h0040_0000, 1'b0, 13'h800, 32'h0, 2'h0);
        acc(32'h017f_ffff, 1'b0, 13'h400, 32'h0, 2'h0);
        cfg = 8'h00;
    endtask
    task automatic t_refuse();
        acc(32'h0400_0000, 1'b0, 13'h0, 32'h0, 2'h1);
        acc(32'hffcf_ffff, 1'b0, 13'h0, 32'h0, 2'h1);
        acc(32'hfffe_f800, 1'b0, 13'h0, 32'h0, 2'h1);
        acc(32'hffff_0000, 1'b0, 13'h0, 32'h0, 2'h1);
        acc(32'hfffe_7000, 1'b0, 13'h0, 32'h0, 2'h1);
        asz = 2'h0;
        acc(32'hffd0_0000, 1'b0, 13'h0, 32'h0, 2'h1);
        asz = 2'h1;
        acc(32'hffd0_3fff, 1'b0, 13'h008, 32'h0, 2'h0);
        asz = 2'h2;
        wp = 6'h3c;
        acc(32'h0100_0000, 1'b1, 13'h0, 32'h0, 2'h2);
        acc(32'h0300_0000, 1'b1, 13'h0, 32'h0, 2'h2);
        wp = 6'h3f;
        acc(32'h0100_0000, 1'b1, 13'h400, 32'h0, 2'h0);
    endtask
    task automatic t_periph();
        acc(32'hffff_5000, 1'b0, 13'h002, 32'h0000_0400, 2'h0);
        chk({30'h0, wd}, 32'h0);
        acc(32'hfffe_0000, 1'b0, 13'h001, 32'h0000_0001, 2'h0);
        chk({30'h0, wd}, 32'h1);
        acc(32'hffff_f800, 1'b0, 13'h002, 32'h8000_0000, 2'h0);
        acc(32'hffff_fc00, 1'b0, 13'h1002, 32'h0, 2'h0);
        acc(32'hfffe_f010, 1'b0, 13'h001, 32'h4000_0000, 2'h0);
    endtask
    task automatic t_reset();
        u_core_model.issue(32'h0400_0000, 1'b1, 2'h2);
        @(posedge i_clk);
        #1;
        chk({28'h0, ab, er, wd}, 32'h6);
        u_core_model.idle();
        i_nrst = 1'b0;
        #1;
        chk({28'h0, ab, er, wd}, 32'h1);
        repeat (2) @(negedge i_clk);
        i_nrst = 1'b1;
        @(posedge i_clk);
        #1;
        chk({30'h0, ab, er}, 32'h0);
    endtask
    task automatic close_out();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            close_out();
        end
    end
    initial begin
        repeat (12) @(posedge i_clk);
        @(negedge i_clk);
        i_nrst = 1'b1;
        t_default();
        t_boot_wide();
        t_refuse();
        t_periph();
        t_reset();
        close_out();
    end
endmodule
`default_nettype wire
